// ===== common/cors_params.svh
`ifndef CORS_PARAMS_SVH
`define CORS_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define CORS_OFS_SYSCFG 4'h0
`define CORS_OFS_WDCTL 4'h4
`define CORS_OFS_STATUS 4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CORS_BIT_CLK_DIS 0
`define CORS_BIT_WD_FLAG 0
`define CORS_BIT_STRAP_A 0
`define CORS_BIT_STRAP_B 1
`define CORS_BIT_BYPASS 2
`define CORS_BIT_CORE_RST 3
`define CORS_BIT_RST_OUT 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CORS_RST_CLK_DIS 1'b0
`define CORS_RST_WD_FLAG 1'b0
`define CORS_RESET_VECTOR 20'hffff0

// ----------------------------------------------------------------
// Timing counts, in clocks after the reset pin is seen released
// ----------------------------------------------------------------
`define CORS_SYNC_STAGES 2
`define CORS_RESET_OUTPUT_HOLD_CLKS 4'h2
// 4.5 clocks, rounded up to whole cycles
`define CORS_EXIT_CLKS 4'h5
// 6.5 clocks, rounded up to whole cycles
`define CORS_FETCH_CLKS 4'h7
// Watchdog reset length, 2^16 clocks
`define CORS_WDT_RESET_CLKS 65536

`endif

// ===== common/cors_pkg.sv
`default_nettype none

package cors_pkg;

    // Avalon-MM slave request from the bus
    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } cors_avs_req_t;

    // Avalon-MM slave answer to the bus
    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
    } cors_avs_rsp_t;

    // Reset sequencer states
    typedef enum logic [2:0] {
        ST_EXT,
        ST_EXIT,
        ST_RUN,
        ST_WDT
    } cors_state_t;

    // Clock output source
    typedef enum logic {
        CM_PLL,
        CM_BYPASS
    } cors_clk_mode_t;

endpackage

`default_nettype wire

// ===== hdl/cors_sync.sv
`default_nettype none

// Multi-stage synchroniser, resets to the asserted level
module cors_sync #(
    parameter int STAGES = 2
) (
    input wire logic clk, // System clock
    input wire logic arst_n, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic d, // Raw level in
    output logic q // Synchronised level
);
    logic [STAGES-1:0] chain;

    // ------------------------------------------------------------
    // Shift chain, only the next stage reads each flop
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chain <= '1;
        end else if (ce) begin
            chain <= {chain[STAGES-2:0], d};
        end
    end

    assign q = chain[STAGES-1];
endmodule

`default_nettype wire

// ===== hdl/cors_top.sv
// Functional notes
// R1: Clock output runs from PLL or source clock as the two straps select.
// R2: Clock output keeps toggling during bus hold and during reset.
// R3: Setting the clock-disable bit stops the clock output.
// R4: Asserting the reset pin aborts activity at once and clears state.
// R5: After reset release the CPU starts at the fixed reset vector.
// R6: External source holds the reset pin low at least 1 ms.
// R7: Reset pin is synchronised internally, may change any time.
// R8: External source keeps reset low over four stable clock periods.
// R9: External reset during a watchdog reset acts as an external reset.
// R10: External reset overriding watchdog reset leaves the watchdog flag clear.
// R11: Overridden watchdog reset exits 4.5 clocks after pin release.
// R12: Instruction fetch starts about 6.5 clocks after pin release.
// R13: Reset output asserts for external or internal resets alike.
// R14: Reset output stays high two clocks after the pin is released.
// R15: Reset pin passes a two-stage synchroniser before sequencing.
//
// Added by the designer: the address map and the Avalon-MM register port.
`include "cors_params.svh"
`default_nettype none

module cors_top #(
    parameter int WDT_RESET_CLKS = `CORS_WDT_RESET_CLKS
) (
    input wire logic clk, // 40 MHz system clock
    input wire logic arst_n, // Async reset, active low
    input wire logic ce, // Clock enable, freezes state
    input wire cors_pkg::cors_avs_req_t avs_req, // Avalon-MM request
    output cors_pkg::cors_avs_rsp_t avs_rsp, // Avalon-MM answer
    input wire logic reset_input_n, // External reset pin
    input wire logic clock_select_strap_a, // Clock strap A
    input wire logic clock_select_strap_b, // Clock strap B
    input wire logic pll_phase, // PLL clock level
    input wire logic src_phase, // Source clock level
    input wire logic wdt_timeout, // Watchdog timeout pulse
    output logic system_clock_output, // Clock to the system
    output logic reset_output, // Reset to peripherals
    output logic core_reset, // Reset to the CPU core
    output logic cpu_fetch_start, // First fetch pulse
    output logic [19:0] reset_vector // CPU start address
);
    import cors_pkg::*;

    localparam int WCNT_W = $clog2(WDT_RESET_CLKS + 1);
    localparam logic [WCNT_W-1:0] WDT_LAST =
        WCNT_W'(WDT_RESET_CLKS - 1);
    localparam logic [3:0] SYNC_CNT = 4'(`CORS_SYNC_STAGES);

    cors_state_t state;
    cors_clk_mode_t clk_mode;
    logic rst_sync;
    logic [3:0] cnt;
    logic [WCNT_W-1:0] wcnt;
    logic clk_dis;
    logic wd_flag;
    logic strap_a;
    logic strap_b;
    logic core_reset_q;
    logic ack_q;
    logic bus_req;
    logic wr_en;
    logic wd_done;
    logic [31:0] rdata_q;

    // ------------------------------------------------------------
    // Reset pin synchroniser
    // ------------------------------------------------------------
    cors_sync #(
        .STAGES(`CORS_SYNC_STAGES)
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .d(~reset_input_n),
        .q(rst_sync)
    ); // [R7] [R15]

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    assign wd_done = (state == ST_WDT) && (wcnt == WDT_LAST);

    // State and post-release counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_EXT;
            cnt <= 4'h0;
        end else if (ce) begin
            if (rst_sync) begin
                state <= ST_EXT; // [R4] [R9]
                cnt <= 4'h0;
            end else begin
                unique case (state)
                    ST_EXT: begin
                        state <= ST_EXIT;
                        cnt <= SYNC_CNT; // [R11]
                    end
                    ST_EXIT: begin
                        if (cnt == `CORS_FETCH_CLKS) begin
                            state <= ST_RUN; // [R12]
                        end else begin
                            cnt <= cnt + 4'h1;
                        end
                    end
                    ST_RUN: begin
                        if (wdt_timeout) begin
                            state <= ST_WDT; // [R13]
                        end
                    end
                    ST_WDT: begin
                        if (wd_done) begin
                            state <= ST_EXIT;
                            cnt <= 4'h0;
                        end
                    end
                endcase
            end
        end
    end

    // Watchdog reset length counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wcnt <= '0;
        end else if (ce) begin
            if (state == ST_WDT && !rst_sync) begin
                wcnt <= wcnt + WCNT_W'(1);
            end else begin
                wcnt <= '0;
            end
        end
    end

    // Reset outputs and fetch pulse
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reset_output <= 1'b1;
            core_reset_q <= 1'b1;
            cpu_fetch_start <= 1'b0;
            reset_vector <= `CORS_RESET_VECTOR;
        end else if (ce) begin
            reset_output <= (state == ST_EXT) || (state == ST_WDT) ||
                ((state == ST_EXIT) && (cnt < `CORS_RESET_OUTPUT_HOLD_CLKS));
            // [R13] [R14]
            core_reset_q <= (state != ST_RUN) &&
                !((state == ST_EXIT) && (cnt >= `CORS_EXIT_CLKS));
            // [R11]
            cpu_fetch_start <= !rst_sync && (state == ST_EXIT) &&
                (cnt == `CORS_FETCH_CLKS); // [R12]
            reset_vector <= `CORS_RESET_VECTOR; // [R5]
        end
    end

    // Pin assertion reaches the core without waiting for sync
    assign core_reset = core_reset_q || !reset_input_n; // [R4]

    // ------------------------------------------------------------
    // Straps and clock output
    // ------------------------------------------------------------
    // Straps follow the pins while held in external reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            strap_a <= 1'b1;
            strap_b <= 1'b1;
        end else if (ce && state == ST_EXT) begin
            strap_a <= clock_select_strap_a;
            strap_b <= clock_select_strap_b;
        end
    end

    assign clk_mode = (!strap_a && !strap_b) ? CM_BYPASS : CM_PLL;

    // The block reset and the clock-disable bit stop it, the pin reset does not
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            system_clock_output <= 1'b0;
        end else if (ce) begin
            if (clk_dis) begin
                system_clock_output <= 1'b0; // [R3]
            end else if (clk_mode == CM_BYPASS) begin
                system_clock_output <= src_phase; // [R1] [R2]
            end else begin
                system_clock_output <= pll_phase; // [R1] [R2]
            end
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM slave, one wait state per access
    // ------------------------------------------------------------
    assign bus_req = avs_req.read || avs_req.write;
    assign avs_rsp.waitrequest = bus_req && !ack_q;
    assign wr_en = ce && ack_q && avs_req.write && avs_req.byteenable[0];
    assign avs_rsp.readdata = rdata_q;

    // Acknowledge and read data capture
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (ce) begin
            ack_q <= bus_req && !ack_q;
            if (avs_req.read && !ack_q) begin
                rdata_q <= 32'h0000_0000;
                unique case (avs_req.address)
                    `CORS_OFS_SYSCFG:
                        rdata_q[`CORS_BIT_CLK_DIS] <= clk_dis;
                    `CORS_OFS_WDCTL:
                        rdata_q[`CORS_BIT_WD_FLAG] <= wd_flag;
                    `CORS_OFS_STATUS: begin
                        rdata_q[`CORS_BIT_STRAP_A] <= strap_a;
                        rdata_q[`CORS_BIT_STRAP_B] <= strap_b;
                        rdata_q[`CORS_BIT_BYPASS] <= (clk_mode == CM_BYPASS);
                        rdata_q[`CORS_BIT_CORE_RST] <= core_reset_q;
                        rdata_q[`CORS_BIT_RST_OUT] <= reset_output;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Clock-disable bit, cleared by block or pin reset, not by a watchdog reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_dis <= `CORS_RST_CLK_DIS;
        end else if (ce) begin
            if (rst_sync) begin
                clk_dis <= `CORS_RST_CLK_DIS; // [R4]
            end else if (wr_en && avs_req.address == `CORS_OFS_SYSCFG) begin
                clk_dis <= avs_req.writedata[`CORS_BIT_CLK_DIS]; // [R3]
            end
        end
    end

    // Watchdog flag: set on finished watchdog reset, write 1 clears
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wd_flag <= `CORS_RST_WD_FLAG;
        end else if (ce) begin
            if (rst_sync) begin
                wd_flag <= 1'b0; // [R10]
            end else if (wd_done) begin
                wd_flag <= 1'b1;
            end else if (wr_en && avs_req.address == `CORS_OFS_WDCTL &&
                         avs_req.writedata[`CORS_BIT_WD_FLAG]) begin
                wd_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    AST_CLK_PLL: assert property ( // [R1]
        (ce && !clk_dis && clk_mode == CM_PLL) |=>
            (system_clock_output == $past(pll_phase)))
        else $error("clock output not following PLL clock");

    AST_CLK_IN_RESET: assert property ( // [R2]
        (ce && state == ST_EXT && !clk_dis && clk_mode == CM_BYPASS) |=>
            (system_clock_output == $past(src_phase)))
        else $error("clock output stopped during reset");

    AST_CLK_DIS: assert property ( // [R3]
        (ce && clk_dis) |=> !system_clock_output)
        else $error("clock output driven while disabled");

    AST_ABORT: assert property ( // [R4]
        !reset_input_n |-> core_reset)
        else $error("core not reset at once by reset pin");

    AST_VECTOR: assert property ( // [R5]
        cpu_fetch_start |-> (!core_reset_q &&
            reset_vector == `CORS_RESET_VECTOR))
        else $error("fetch start without reset vector");

    AST_SYNC_DELAY: assert property ( // [R7]
        (ce && state == ST_RUN && !reset_input_n && !rst_sync) |=>
            (state != ST_EXT))
        else $error("reset pin used without synchroniser");

    AST_WDT_OVERRIDE: assert property ( // [R9]
        (ce && state == ST_WDT && rst_sync) |=>
            (state == ST_EXT && !wd_flag))
        else $error("external reset did not override watchdog");

    AST_FLAG_CLEAR: assert property ( // [R10]
        (ce && rst_sync) |=> !wd_flag)
        else $error("watchdog flag set after external reset");

    AST_RESET_OUTPUT: assert property ( // [R13]
        (ce && (state == ST_EXT || state == ST_WDT)) |=> reset_output)
        else $error("reset output low during reset");

    AST_HOLD: assert property ( // [R14]
        (ce && !rst_sync && state == ST_EXIT && cnt == SYNC_CNT) |=>
            !reset_output)
        else $error("reset output hold length wrong");

    AST_EXIT: assert property ( // [R11]
        (ce && !rst_sync && state == ST_EXIT && cnt == `CORS_EXIT_CLKS) |=>
            !core_reset_q)
        else $error("core reset not released on time");

    COV_EXT_RESET: cover property (
        (state == ST_EXIT) ##[1:20] cpu_fetch_start);
    COV_WDT_DONE: cover property (wd_done);
    COV_OVERRIDE: cover property ((state == ST_WDT) ##1 (state == ST_EXT));
    COV_BUS_WRITE: cover property (wr_en);
endmodule

`default_nettype wire

// ===== testbench/cors_rst_src.sv
`default_nettype none

// ----------------------------------------------------------------
// External reset circuit driving the reset pin
// ----------------------------------------------------------------
module cors_rst_src #(
    parameter int HOLD_CLKS = 40000
) (
    input wire logic clk, // System clock
    output logic reset_input_n // Reset pin, active low
);
    timeunit 1ns;
    timeprecision 100ps;

    // Pin idles released
    initial reset_input_n = 1'b1;

    // Pull the pin low at once, without waiting for a clock edge
    task automatic drive_low();
        reset_input_n <= 1'b0;
    endtask

    // Keep it low long enough to settle, over four clock periods
    task automatic hold();
        repeat (HOLD_CLKS) @(posedge clk);
    endtask

    // Let the pin go
    task automatic release_pin();
        reset_input_n <= 1'b1;
    endtask
endmodule

`default_nettype wire

// ===== testbench/tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // Stimulus and design
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    cors_pkg::cors_avs_req_t req = '0;
    cors_pkg::cors_avs_rsp_t rsp;
    wire logic reset_input_n;
    logic strap_a = 1'b0;
    logic strap_b = 1'b0;
    logic pll_phase = 1'b0;
    logic src_phase = 1'b0;
    logic wdt_timeout = 1'b0;
    logic system_clock_output;
    logic reset_output;
    logic core_reset;
    logic cpu_fetch_start;
    logic [19:0] reset_vector;
    int err_total = 0;
    int checks_done = 0;
    int seed = 32'h2ac0d35e;
    // Model state, edge counts after the pin is released
    int m_dis = 0;
    int m_byp = 1;
    localparam int RO_EDGES = 3;
    localparam int EXIT_EDGES = 6;
    localparam int FETCH_EDGES = 8;

    // Clock at 40 MHz
    always #12.5 clk = ~clk;

    // Random clock phases into the selector
    always @(posedge clk) begin
        {pll_phase, src_phase} <= 2'($random(seed));
    end

    cors_rst_src #(.HOLD_CLKS(8)) src_u (
        .clk(clk),
        .reset_input_n(reset_input_n)
    );

    cors_top #(.WDT_RESET_CLKS(16)) dut_u (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .avs_req(req),
        .avs_rsp(rsp),
        .reset_input_n(reset_input_n),
        .clock_select_strap_a(strap_a),
        .clock_select_strap_b(strap_b),
        .pll_phase(pll_phase),
        .src_phase(src_phase),
        .wdt_timeout(wdt_timeout),
        .system_clock_output(system_clock_output),
        .reset_output(reset_output),
        .core_reset(core_reset),
        .cpu_fetch_start(cpu_fetch_start),
        .reset_vector(reset_vector)
    );

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Compare one value
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        req.read <= !wr;
        req.write <= wr;
        req.address <= a;
        req.writedata <= d;
        req.byteenable <= 4'hf;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 20);
        if (rsp.waitrequest !== 1'b0) begin
            err_total++;
            finish_test();
        end
        q = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge clk);
    endtask

    // Read a register and compare
    task automatic rd_chk(input string nm, input logic [3:0] a,
                          input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, q, exp);
    endtask

    // Follow the clock output for n cycles
    task automatic ck(input int n);
        logic expq[$];
        logic exp;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            if (i > 0) begin
                exp = expq.pop_front();
                chk("clk_out", system_clock_output, exp);
            end
            expq.push_back(m_dis ? 1'b0 : (m_byp ? src_phase : pll_phase));
        end
    endtask

    // Pin low, immediate core reset, hold, reset output up
    task automatic pin_reset();
        src_u.drive_low();
        #1;
        chk("core_now", core_reset, 1'b1);
        src_u.hold();
        #1;
        chk("ro_in_rst", reset_output, 1'b1);
        m_dis = 0;
    endtask

    // Release the pin and time every step of the exit
    task automatic release_meas();
        int t_ro, t_cr, t_fe, fe_n;
        t_ro = 0;
        t_cr = 0;
        t_fe = 0;
        fe_n = 0;
        src_u.release_pin();
        for (int k = 1; k <= 30; k++) begin
            @(posedge clk);
            #1;
            if (reset_output === 1'b0 && t_ro == 0) t_ro = k;
            if (core_reset === 1'b0 && t_cr == 0) t_cr = k;
            if (cpu_fetch_start === 1'b1) begin
                fe_n++;
                if (t_fe == 0) t_fe = k;
            end
        end
        chk("ro_exit", t_ro, 1 + RO_EDGES);
        chk("core_exit", t_cr, 1 + EXIT_EDGES);
        chk("fetch_at", t_fe, 1 + FETCH_EDGES);
        chk("fetch_len", fe_n, 1);
        chk("vector", reset_vector, 20'hffff0);
    endtask

    // One-cycle watchdog timeout pulse
    task automatic wdt_pulse();
        @(posedge clk);
        wdt_timeout <= 1'b1;
        @(posedge clk);
        wdt_timeout <= 1'b0;
        @(posedge clk);
        #1;
        chk("ro_wdt", reset_output, 1'b1);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] q;
        int n;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (12) @(posedge clk);
        // Every strap setting, clock checked in and out of reset
        for (int i = 0; i < 4; i++) begin
            pin_reset();
            @(posedge clk);
            strap_a <= i[0];
            strap_b <= i[1];
            m_byp = (i == 0);
            repeat (2) @(posedge clk);
            ck(6);
            release_meas();
            ck(6);
            rd_chk("status", 4'h8, {27'h0, 2'b00, m_byp[0], i[1:0]});
        end
        $display("test straps and exit timing done");
        // Clock enable low freezes the clock output
        @(posedge clk);
        ce <= 1'b0;
        #1;
        q = {31'h0, system_clock_output};
        repeat (4) begin
            @(posedge clk);
            #1;
            chk("ce_freeze", system_clock_output, q);
        end
        @(posedge clk);
        ce <= 1'b1;
        $display("test clock enable done");
        // Clock disable, then cleared by a pin reset
        bus(1'b1, 4'h0, 32'h1, q);
        m_dis = 1;
        rd_chk("disable", 4'h0, 32'h1);
        ck(8);
        rd_chk("unmapped", 4'hc, 32'h0);
        pin_reset();
        release_meas();
        rd_chk("dis_clr", 4'h0, 32'h0);
        ck(8);
        $display("test clock disable done");
        // Watchdog reset runs to completion and sets the flag
        wdt_pulse();
        repeat (10) @(posedge clk);
        #1;
        chk("ro_wdt_hold", reset_output, 1'b1);
        n = 0;
        while (cpu_fetch_start !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (cpu_fetch_start !== 1'b1) begin
            err_total++;
            finish_test();
        end
        rd_chk("wd_flag", 4'h4, 32'h1);
        bus(1'b1, 4'h4, 32'h1, q);
        rd_chk("wd_flag_clr", 4'h4, 32'h0);
        $display("test watchdog reset done");
        // Pin reset overrides a watchdog reset in progress
        wdt_pulse();
        repeat (3) @(posedge clk);
        pin_reset();
        release_meas();
        rd_chk("wd_flag_ovr", 4'h4, 32'h0);
        $display("test watchdog override done");
        finish_test();
    end

    // Cut a hang short
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        finish_test();
    end
endmodule

`default_nettype wire
